//--- t1pm_counters.sv
// Decided for this implementation: the Wishbone interface to the registers.
`timescale 1ns/1ps
`include "t1pm_defs.svh"
module t1pm_counters #(
    parameter int CNT_W = 16,
    parameter int SEF_W = 8
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    // classic wishbone slave
    input wire logic cyc_i,
    input wire logic stb_i,
    input wire logic we_i,
    input wire logic [15:0] adr_i,
    input wire logic [3:0] sel_i,
    input wire logic [31:0] dat_i,
    output logic [31:0] dat_o,
    output logic ack_o,
    // receive framer events, one-cycle pulses
    input wire logic fa_err_i,
    input wire logic sync_err_i,
    input wire logic sframe_end_i,
    input wire logic sframe_bad_i,
    output logic irq_o
);
    if (CNT_W != 16 || SEF_W != 8) begin : g_bad_param
        $error("t1pm_counters: byte register layout needs CNT_W 16 and SEF_W 8");
    end

    // ---------------- bus decode ----------------
    logic ack_q;
    logic ack_d;
    logic [31:0] dat_q;
    logic [31:0] dat_d;
    logic take;
    logic rd;
    logic wr;
    t1pm_pkg::t1pm_idx_t idx;

    assign idx = adr_i[15:2];
    assign take = cyc_i && stb_i && !ack_q;
    assign rd = take && !we_i;
    assign wr = take && we_i && sel_i[0];

    // pair 0 is framing alignment, pair 1 is synchronization
    logic [1:0] rd_hi;
    logic [1:0] rd_lo;
    logic [1:0] pair_ev;
    logic [CNT_W-1:0] cnt [2];
    logic [7:0] lo_q [2];
    logic [7:0] lo_d [2];
    logic [1:0] pend_q;
    logic [1:0] pend_d;

    assign rd_hi[0] = rd && idx == `T1PM_IDX_FA_HIGH;
    assign rd_lo[0] = rd && idx == `T1PM_IDX_FA_LOW;
    // own index for the lower sync byte
    assign rd_hi[1] = rd && idx == `T1PM_IDX_SYNC_HIGH;
    assign rd_lo[1] = rd && idx == `T1PM_IDX_SYNC_LOW;
    assign pair_ev[0] = fa_err_i;
    assign pair_ev[1] = sync_err_i;

    genvar g;
    for (g = 0; g < 2; g++) begin : g_pair
        logic clr;
        // upper read clears the count, lower read releases the snapshot
        assign clr = rd_hi[g] || (rd_lo[g] && !pend_q[g]);

        t1pm_sat_cnt #(
            .W(CNT_W)
        ) u_cnt (
            .clk_sys_i(clk_sys_i),
            .rst_i(rst_i),
            .inc_i(pair_ev[g]),
            .clr_i(clr),
            .count_o(cnt[g])
        );

        // lower byte frozen at the upper read so the pair is coherent
        always_comb begin
            lo_d[g] = lo_q[g];
            pend_d[g] = pend_q[g];
            if (rd_hi[g]) begin
                lo_d[g] = cnt[g][7:0];
                pend_d[g] = 1'b1;
            end else if (rd_lo[g]) begin
                lo_d[g] = 8'h00;
                pend_d[g] = 1'b0;
            end
        end

        always_ff @(posedge clk_sys_i) begin
            if (rst_i) begin
                lo_q[g] <= 8'h00;
                pend_q[g] <= 1'b0;
            end else begin
                lo_q[g] <= lo_d[g];
                pend_q[g] <= pend_d[g];
            end
        end

        // snapshot equals the low byte seen at the upper read
        a_lo_snapshot: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            rd_hi[g] |=> lo_q[g] == $past(cnt[g][7:0]) && pend_q[g])
            else $error("lower byte snapshot wrong");
        // ordered pair of reads leaves the snapshot clear
        a_pair_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            rd_lo[g] && pend_q[g] |=> lo_q[g] == 8'h00 && !pend_q[g])
            else $error("lower read did not clear snapshot");
        a_hi_clears: assert property (@(posedge clk_sys_i) disable iff (rst_i)
            rd_hi[g] |=> cnt[g] <= CNT_W'(1))
            else $error("upper read did not clear counter");
    end

    // ---------------- severely errored frames ----------------
    logic ctrl_q;
    logic ctrl_d;
    t1pm_pkg::t1pm_mode_t mode;
    logic [4:0] run_q;
    logic [4:0] run_d;
    logic [4:0] run_target;
    logic sef_ev;
    logic rd_sef;
    logic [SEF_W-1:0] sef_cnt;

    assign mode = ctrl_q ? t1pm_pkg::T1PM_MODE_ESF : t1pm_pkg::T1PM_MODE_SF;

    always_comb begin
        run_target = `T1PM_SF_RUN;
        unique case (mode)
            t1pm_pkg::T1PM_MODE_SF: run_target = `T1PM_SF_RUN;
            t1pm_pkg::T1PM_MODE_ESF: run_target = `T1PM_ESF_RUN;
        endcase
    end

    // one event per full run; a still-bad line starts a fresh window
    always_comb begin
        run_d = run_q;
        sef_ev = 1'b0;
        if (ctrl_d != ctrl_q) begin
            run_d = 5'h00;
        end else if (sframe_end_i) begin
            if (!sframe_bad_i) begin
                run_d = 5'h00;
            // declare at end of the run
            end else if (run_q + 5'h01 == run_target) begin
                run_d = 5'h00;
                sef_ev = 1'b1;
            end else begin
                run_d = run_q + 5'h01;
            end
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            run_q <= 5'h00;
        end else begin
            run_q <= run_d;
        end
    end

    assign rd_sef = rd && idx == `T1PM_IDX_SEF;

    t1pm_sat_cnt #(
        .W(SEF_W)
    ) u_sef_cnt (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .inc_i(sef_ev),
        .clr_i(rd_sef),
        .count_o(sef_cnt)
    );

    // no event before the sixth bad superframe
    a_sef_sf_run: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        sef_ev && mode == t1pm_pkg::T1PM_MODE_SF |-> run_q == 5'h05 && sframe_bad_i)
        else $error("superframe event at wrong run length");
    // no event before the twenty-fourth bad extended superframe
    a_sef_esf_run: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        sef_ev && mode == t1pm_pkg::T1PM_MODE_ESF |-> run_q == 5'h17 && sframe_bad_i)
        else $error("extended superframe event at wrong run length");

    // ---------------- control and interrupts ----------------
    logic [2:0] stat_q;
    logic [2:0] stat_d;
    logic [2:0] mask_q;
    logic [2:0] mask_d;
    logic [2:0] ev;

    assign ev[`T1PM_IRQ_FA_BIT] = fa_err_i;
    assign ev[`T1PM_IRQ_SEF_BIT] = sef_ev;
    assign ev[`T1PM_IRQ_SYNC_BIT] = sync_err_i;

    // set wins over a write-one clear in the same cycle
    always_comb begin
        ctrl_d = ctrl_q;
        mask_d = mask_q;
        stat_d = stat_q | ev;
        if (wr && idx == `T1PM_IDX_CTRL) begin
            ctrl_d = dat_i[`T1PM_CTRL_ESF_BIT];
        end
        if (wr && idx == `T1PM_IDX_IRQ_MASK) begin
            mask_d = dat_i[2:0];
        end
        if (wr && idx == `T1PM_IDX_IRQ_STAT) begin
            stat_d = (stat_q & ~dat_i[2:0]) | ev;
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ctrl_q <= `T1PM_CTRL_RST;
            mask_q <= `T1PM_IRQ_RST;
            stat_q <= `T1PM_IRQ_RST;
        end else begin
            ctrl_q <= ctrl_d;
            mask_q <= mask_d;
            stat_q <= stat_d;
        end
    end

    assign irq_o = |(stat_q & mask_q);

    a_irq_set_wins: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        fa_err_i |=> stat_q[`T1PM_IRQ_FA_BIT])
        else $error("event lost in status register");

    // ---------------- read mux and ack ----------------
    // unmapped indices answer with zero and ignore writes
    always_comb begin
        ack_d = take;
        dat_d = dat_q;
        if (rd) begin
            dat_d = 32'h0000_0000;
            unique case (idx)
                `T1PM_IDX_FA_HIGH: dat_d[7:0] = cnt[0][15:8];
                `T1PM_IDX_FA_LOW: dat_d[7:0] = pend_q[0] ? lo_q[0] : cnt[0][7:0];
                `T1PM_IDX_SEF: dat_d[7:0] = sef_cnt;
                `T1PM_IDX_SYNC_HIGH: dat_d[7:0] = cnt[1][15:8];
                // lower sync byte in bits 7..0
                `T1PM_IDX_SYNC_LOW: dat_d[7:0] = pend_q[1] ? lo_q[1] : cnt[1][7:0];
                `T1PM_IDX_CTRL: dat_d[0] = ctrl_q;
                `T1PM_IDX_IRQ_STAT: dat_d[2:0] = stat_q;
                `T1PM_IDX_IRQ_MASK: dat_d[2:0] = mask_q;
                default: dat_d = 32'h0000_0000;
            endcase
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            ack_q <= 1'b0;
            dat_q <= 32'h0000_0000;
        end else begin
            ack_q <= ack_d;
            dat_q <= dat_d;
        end
    end

    assign ack_o = ack_q;
    assign dat_o = dat_q;

    a_ack_follows: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        take |=> ack_o ##1 !ack_o)
        else $error("ack not a single cycle after request");
    // lower sync read returns the snapshot when one is pending
    a_sync_lo_data: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        rd_lo[1] && pend_q[1] |=> dat_o == {24'h000000, $past(lo_q[1])})
        else $error("lower sync byte read data wrong");
endmodule

//--- t1pm_defs.svh
`ifndef T1PM_DEFS_SVH
`define T1PM_DEFS_SVH

// register indices; byte address is four times the index
`define T1PM_IDX_FA_HIGH 14'h0902
`define T1PM_IDX_FA_LOW 14'h0903
`define T1PM_IDX_SEF 14'h0904
`define T1PM_IDX_SYNC_HIGH 14'h0905
`define T1PM_IDX_SYNC_LOW 14'h0906
`define T1PM_IDX_CTRL 14'h0910
`define T1PM_IDX_IRQ_STAT 14'h0911
`define T1PM_IDX_IRQ_MASK 14'h0912

// field positions
`define T1PM_CTRL_ESF_BIT 0
`define T1PM_IRQ_FA_BIT 0
`define T1PM_IRQ_SEF_BIT 1
`define T1PM_IRQ_SYNC_BIT 2

// reset values
`define T1PM_CNT_RST 16'h0000
`define T1PM_CTRL_RST 1'h0
`define T1PM_IRQ_RST 3'h0

// severely errored frame windows, in superframes and in time
`define T1PM_SF_RUN 5'h06
`define T1PM_ESF_RUN 5'h18
`define T1PM_SF_WINDOW_US 750
`define T1PM_ESF_WINDOW_US 3000
`endif

//--- t1pm_pkg.sv
package t1pm_pkg;
    typedef enum logic [1:0] {
        T1PM_MODE_SF = 2'h1,
        T1PM_MODE_ESF = 2'h2
    } t1pm_mode_t;
    typedef logic [13:0] t1pm_idx_t;
endpackage

//--- t1pm_sat_cnt.sv
`timescale 1ns/1ps
`include "t1pm_defs.svh"
module t1pm_sat_cnt #(
    parameter int W = 16
) (
    input wire logic clk_sys_i,
    input wire logic rst_i,
    input wire logic inc_i,
    input wire logic clr_i,
    output logic [W-1:0] count_o
);
    if (W < 8 || W > 16) begin : g_bad_width
        $error("t1pm_sat_cnt: W must be 8..16");
    end

    logic [W-1:0] count_q;
    logic [W-1:0] count_d;
    localparam logic [W-1:0] ALL_ONES = {W{1'b1}};

    // event in the clearing cycle is kept, counted as one
    always_comb begin
        count_d = count_q;
        if (clr_i) begin
            count_d = {{(W-1){1'b0}}, inc_i};
        end else if (inc_i && count_q != ALL_ONES) begin
            count_d = count_q + {{(W-1){1'b0}}, 1'b1};
        end
    end

    always_ff @(posedge clk_sys_i) begin
        if (rst_i) begin
            count_q <= W'(`T1PM_CNT_RST);
        end else begin
            count_q <= count_d;
        end
    end

    assign count_o = count_q;

    a_sat_holds: assert property (@(posedge clk_sys_i) disable iff (rst_i)
        (count_q == ALL_ONES && !clr_i) |=> count_q == ALL_ONES)
        else $error("saturated counter moved");
    a_reset_zero: assert property (@(posedge clk_sys_i)
        $past(rst_i) |-> count_q == '0)
        else $error("counter not zero after reset");
endmodule

//--- test_t1_rx_error_counters.sv
`timescale 1ns/1ps
`include "t1pm_defs.svh"
module test_t1_rx_error_counters;
    typedef struct {
        logic [3:0] ev;
        int n;
        t1pm_pkg::t1pm_idx_t idx;
        logic [31:0] hi;
        logic [31:0] lo;
    } t1pm_row_t;

    logic clk_sys_i = 1'b0;
    logic rst_i = 1'b1;
    logic cyc = 1'b0;
    logic stb = 1'b0;
    logic we = 1'b0;
    logic [15:0] adr = 16'h0000;
    logic [3:0] sel = 4'hF;
    logic [31:0] wdat = 32'h00000000;
    logic [31:0] dat_o;
    logic ack_o;
    logic fa = 1'b0;
    logic sync = 1'b0;
    logic send = 1'b0;
    logic sbad = 1'b0;
    logic irq_o;
    logic [31:0] rd;
    int mismatches = 0;
    int n_compared = 0;
    t1pm_row_t rows [4];

    initial forever #50 clk_sys_i = ~clk_sys_i;

    t1pm_counters dut_u (
        .clk_sys_i(clk_sys_i),
        .rst_i(rst_i),
        .cyc_i(cyc),
        .stb_i(stb),
        .we_i(we),
        .adr_i(adr),
        .sel_i(sel),
        .dat_i(wdat),
        .dat_o(dat_o),
        .ack_o(ack_o),
        .fa_err_i(fa),
        .sync_err_i(sync),
        .sframe_end_i(send),
        .sframe_bad_i(sbad),
        .irq_o(irq_o)
    );

    task automatic summarize;
        $display("compared %0d mismatches %0d", n_compared, mismatches);
        if (mismatches == 0 && n_compared > 0) begin
            $display("RESULT: PASS");
        end else begin
            $display("RESULT: FAIL");
        end
        $finish;
    endtask

    task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
        n_compared++;
        if (seen !== exp) begin
            mismatches++;
            $display("mismatch at %0t: seen %h expected %h", $time, seen, exp);
        end
    endtask

    // one classic cycle; the bench never assumes the slave latency
    task automatic wb(input logic w, input t1pm_pkg::t1pm_idx_t idx, input logic [31:0] wd,
                      output logic [31:0] rdata);
        int n;
        n = 0;
        @(posedge clk_sys_i);
        cyc <= 1'b1;
        stb <= 1'b1;
        we <= w;
        adr <= {idx, 2'b00};
        wdat <= wd;
        do begin
            @(posedge clk_sys_i);
            n++;
        end while (ack_o !== 1'b1 && n < 16);
        if (ack_o !== 1'b1) begin
            mismatches++;
            summarize();
        end
        rdata = dat_o;
        cyc <= 1'b0;
        stb <= 1'b0;
        we <= 1'b0;
    endtask

    task automatic rdchk(input t1pm_pkg::t1pm_idx_t idx, input logic [31:0] exp);
        logic [31:0] v;
        wb(1'b0, idx, 32'h00000000, v);
        chk(v, exp);
    endtask

    // order of v: framing error, sync error, superframe end, superframe bad
    task automatic ev(input logic [3:0] v, input int n);
        repeat (n) begin
            @(posedge clk_sys_i);
            {fa, sync, send, sbad} <= v;
        end
        @(posedge clk_sys_i);
        {fa, sync, send, sbad} <= 4'h0;
    endtask

    initial begin
        rows[0] = '{4'h8, 3, `T1PM_IDX_FA_HIGH, 32'h00, 32'h03};
        rows[1] = '{4'h8, 300, `T1PM_IDX_FA_HIGH, 32'h01, 32'h2C};
        rows[2] = '{4'h4, 5, `T1PM_IDX_SYNC_HIGH, 32'h00, 32'h05};
        rows[3] = '{4'h4, 257, `T1PM_IDX_SYNC_HIGH, 32'h01, 32'h01};
        repeat (12) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        for (int i = 0; i < 5; i++) begin
            rdchk(`T1PM_IDX_FA_HIGH + 14'(i), 32'h00000000);
        end
        chk({31'h0, irq_o}, 32'h0);
        foreach (rows[i]) begin
            ev(rows[i].ev, rows[i].n);
            rdchk(rows[i].idx, rows[i].hi);
            rdchk(rows[i].idx + 14'h0001, rows[i].lo);
            rdchk(rows[i].idx + 14'h0001, 32'h00000000);
        end
        // sticky status, mask gating, write-one-to-clear
        chk({31'h0, irq_o}, 32'h0);
        rdchk(`T1PM_IDX_IRQ_STAT, 32'h5);
        wb(1'b1, `T1PM_IDX_IRQ_MASK, 32'h1, rd);
        chk({31'h0, irq_o}, 32'h1);
        wb(1'b1, `T1PM_IDX_IRQ_STAT, 32'h1, rd);
        chk({31'h0, irq_o}, 32'h0);
        rdchk(`T1PM_IDX_IRQ_STAT, 32'h4);
        rdchk(14'h0000, 32'h00000000);
        wb(1'b1, `T1PM_IDX_FA_LOW, 32'hAA, rd);
        rdchk(`T1PM_IDX_FA_LOW, 32'h00000000);
        // event taken at the same edge as its write-one clear: set wins
        fork
            wb(1'b1, `T1PM_IDX_IRQ_STAT, 32'h1, rd);
            ev(4'h8, 1);
        join
        chk({31'h0, irq_o}, 32'h1);
        rdchk(`T1PM_IDX_IRQ_STAT, 32'h5);
        rdchk(`T1PM_IDX_FA_LOW, 32'h01);
        // write without byte lane 0 is ignored
        sel <= 4'h0;
        wb(1'b1, `T1PM_IDX_IRQ_MASK, 32'h0, rd);
        sel <= 4'hF;
        rdchk(`T1PM_IDX_IRQ_MASK, 32'h1);
        // low byte must stay frozen while new errors arrive
        ev(4'h8, 258);
        rdchk(`T1PM_IDX_FA_HIGH, 32'h01);
        ev(4'h8, 5);
        rdchk(`T1PM_IDX_FA_LOW, 32'h02);
        // a good superframe breaks the run
        ev(4'h3, 5);
        ev(4'h2, 1);
        ev(4'h3, 6);
        rdchk(`T1PM_IDX_SEF, 32'h01);
        rdchk(`T1PM_IDX_SEF, 32'h00);
        wb(1'b1, `T1PM_IDX_CTRL, 32'h1, rd);
        ev(4'h3, 23);
        rdchk(`T1PM_IDX_SEF, 32'h00);
        ev(4'h3, 1);
        rdchk(`T1PM_IDX_SEF, 32'h01);
        wb(1'b1, `T1PM_IDX_CTRL, 32'h0, rd);
        // long enough to pass every counter's all-ones value
        ev(4'hF, 65540);
        rdchk(`T1PM_IDX_FA_HIGH, 32'hFF);
        rdchk(`T1PM_IDX_FA_LOW, 32'hFF);
        rdchk(`T1PM_IDX_SEF, 32'hFF);
        rdchk(`T1PM_IDX_SYNC_HIGH, 32'hFF);
        rdchk(`T1PM_IDX_SYNC_LOW, 32'hFF);
        ev(4'h4, 3);
        @(posedge clk_sys_i);
        rst_i <= 1'b1;
        repeat (3) @(posedge clk_sys_i);
        rst_i <= 1'b0;
        rdchk(`T1PM_IDX_SYNC_LOW, 32'h00);
        summarize();
    end
endmodule
